// >>> logic/local_irq_status.v
// Summary of operation
// - All qualified interrupt sources are ORed onto one local interrupt line.
// - Bridge configuration bit 11 further gates the line toward the host.
// - A source asserts only with its flag, its enable and global enable high.
// - Status bit 15 reads back the auto-clear bit of the enable register.
// - With auto-clear set, reading status clears global enable, dropping the line.
// - Global enable bit 14 is read/write in the status register.
// - Parity errors latch bit 13 only while parity is enabled; write zero clears.
// - With parity on, only 32/64-bit accesses are checked; narrower writes blocked.
// - Blocked narrow writes in parity mode latch bit 12; write zero clears.
// - Receiver sync loss latches bit 11; write zero clears.
// - Receive FIFO full latches bit 10 until zero is written.
// - Receive FIFO almost full latches bit 9; host should pause accesses.
// - Receiver invalid data latches bit 8; cleared only by writing zero.
// - Bit 7 shows type-four network interrupts are queued.
// - Rogue packet removal as rogue master latches bit 6; write zero clears.
// - Transmit FIFO full latches bit 5; write zero clears.
// - Reset request from another node sets bit 3; host performs the reset.
// - Bits 0 to 2 show pending network interrupts of types one to three.
// - Upper sixteen bits and bit 4 are reserved and read zero.
// - Enable register mirrors status bit positions, one enable per source.
// - Command low three bits: zero is node reset, 1,2,3,7 network interrupts.
`include "local_irq_defines.vh"

module local_irq_status (
  input  wire        clk_i,            // Board clock, 100 MHz
  input  wire        rst_b_i,          // Asynchronous reset, active low
  input  wire        reg_wr_i,         // Register write strobe, one cycle
  input  wire        reg_rd_i,         // Register read strobe, one cycle
  input  wire [7:0]  reg_addr_i,       // Register byte offset
  input  wire [31:0] reg_wdata_i,      // Register write data
  output reg  [31:0] reg_rdata_o,      // Read data, valid the cycle after reg_rd_i
  input  wire        bridge_gate_i,    // Bridge local configuration bit 11
  input  wire        parity_en_i,      // Parity enable from control register 1
  input  wire        mem_acc_i,        // Local memory access strobe
  input  wire        mem_wr_i,         // Access is a write
  input  wire [3:0]  mem_be_i,         // Byte lanes of the access
  input  wire        mem_par_err_i,    // Parity error seen on the access
  input  wire        sync_loss_i,      // Receiver lost synchronization (pin)
  input  wire        rx_full_i,        // Receive FIFO full (pin)
  input  wire        rx_afull_i,       // Receive FIFO almost full (pin)
  input  wire        bad_data_i,       // Receiver invalid data (pin)
  input  wire        rogue_removed_i,  // Rogue packet removed (pulse)
  input  wire        rogue_master_i,   // Board is rogue master 0 or 1
  input  wire        tx_full_i,        // Transmit FIFO full
  input  wire        rx_cmd_valid_i,   // Received network command, one cycle
  input  wire [2:0]  rx_cmd_type_i,    // Received command type code
  input  wire [3:0]  queue_nonempty_i, // Sender queues 1..4 hold entries
  output reg         mem_wr_block_o,   // Write of the previous cycle was inhibited
  output reg         local_irq_out_n_o,// Local interrupt line, active low
  output reg         host_irq_n_o      // Host interrupt after bridge gate, active low
);

  reg  [1:0]  sync_loss_s;
  reg  [1:0]  rx_full_s;
  reg  [1:0]  rx_afull_s;
  reg  [1:0]  bad_data_s;
  reg  [3:0]  fault_prev;
  wire [15:0] status;
  reg  [15:0] enable;
  reg         narrow_wr;
  wire [15:0] next_status;
  reg  [15:0] set_vec;
  wire [15:0] status_view;
  wire [15:0] next_view;
  wire [15:0] pending;
  wire        st_wr;
  wire        st_rd;
  wire [3:0]  fault_now;

  localparam [15:0] LATCH_MASK = `LIS_LATCH_MASK;
  localparam [15:0] STATUS_RST = `LIS_STATUS_RST;

  genvar            k;

  // Pin inputs pass two flops; the edge logic reads only the second stage
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_loss_s <= 2'h0;
      rx_full_s   <= 2'h0;
      rx_afull_s  <= 2'h0;
      bad_data_s  <= 2'h0;
      fault_prev  <= 4'h0;
    end else begin
      sync_loss_s <= {sync_loss_s[0], sync_loss_i};
      rx_full_s   <= {rx_full_s[0], rx_full_i};
      rx_afull_s  <= {rx_afull_s[0], rx_afull_i};
      bad_data_s  <= {bad_data_s[0], bad_data_i};
      fault_prev  <= fault_now;
    end
  end

  assign fault_now = {sync_loss_s[1], rx_full_s[1], rx_afull_s[1], bad_data_s[1]};
  assign st_wr = reg_wr_i && (reg_addr_i == `LIS_STATUS_OFS);
  assign st_rd = reg_rd_i && (reg_addr_i == `LIS_STATUS_OFS);

  // Any lane missing means an 8, 16 or 24-bit write
  always @* begin
    narrow_wr = mem_acc_i && mem_wr_i && (mem_be_i != 4'hF);
  end

  // Flag events, one bit per source; the four pin sources latch on their rising edge, tx_full_i on its level
  always @* begin
    set_vec = 16'h0000;
    set_vec[`LIS_PARITY_BIT]    = parity_en_i && mem_acc_i && mem_par_err_i
                                  && (mem_be_i == 4'hF);
    set_vec[`LIS_WR_INH_BIT]    = parity_en_i && narrow_wr;
    set_vec[`LIS_SYNC_LOSS_BIT] = fault_now[3] && !fault_prev[3];
    set_vec[`LIS_RXF_FULL_BIT]  = fault_now[2] && !fault_prev[2];
    set_vec[`LIS_RXF_AFULL_BIT] = fault_now[1] && !fault_prev[1];
    set_vec[`LIS_BAD_DATA_BIT]  = fault_now[0] && !fault_prev[0];
    set_vec[`LIS_ROGUE_BIT]     = rogue_master_i && rogue_removed_i;
    set_vec[`LIS_TXF_FULL_BIT]  = tx_full_i;
    set_vec[`LIS_RST_REQ_BIT]   = rx_cmd_valid_i
                                  && (rx_cmd_type_i == `LIS_CMD_RESET);
  end

  // Pending bits are live queue state, not latched
  assign status_view = {enable[`LIS_AUTOCLR_BIT], status[14:8],
                        queue_nonempty_i[3], status[6:3],
                        queue_nonempty_i[2:0]} & 16'hFFEF;

  // One flag per position; set wins over a written zero, written ones set only the global enable
  generate
    for (k = 0; k < 16; k = k + 1) begin : g_flag
      reg flag_q;
      if (LATCH_MASK[k]) begin : g_latch
        assign next_status[k] = set_vec[k]
                              | (status[k] & ~(st_wr & ~reg_wdata_i[k]));
      end else if (k == `LIS_GLOBAL_EN_BIT) begin : g_global
        // Auto-clear is applied after a same-cycle write so the read still wins
        assign next_status[k] = !(st_rd && enable[`LIS_AUTOCLR_BIT])
                              && (st_wr ? reg_wdata_i[k] : status[k]);
      end else begin : g_live
        // Live or reserved positions keep no state here
        assign next_status[k] = 1'b0;
      end
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          flag_q <= STATUS_RST[k];
        end else begin
          flag_q <= next_status[k];
        end
      end
      assign status[k] = flag_q;
    end
  endgenerate

  // Qualify on the next state so a clear or auto-clear drops the line at once
  assign next_view = {enable[`LIS_AUTOCLR_BIT], next_status[14:8],
                      queue_nonempty_i[3], next_status[6:3],
                      queue_nonempty_i[2:0]} & 16'hFFEF;

  // Sources qualified by flag and enable; global enable is applied at the outputs
  assign pending = next_view & enable & `LIS_ENABLE_MASK & 16'h7FFF;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable            <= `LIS_ENABLE_RST;
      reg_rdata_o       <= 32'h00000000;
      mem_wr_block_o    <= 1'b0;
      local_irq_out_n_o <= 1'b1;
      host_irq_n_o      <= 1'b1;
    end else begin
      if (reg_wr_i && (reg_addr_i == `LIS_ENABLE_OFS))
        enable <= reg_wdata_i[15:0] & `LIS_ENABLE_MASK;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `LIS_STATUS_OFS: reg_rdata_o <= {16'h0000, status_view};
          `LIS_ENABLE_OFS: reg_rdata_o <= {16'h0000, enable};
          default:         reg_rdata_o <= 32'h00000000;
        endcase
      end
      mem_wr_block_o    <= parity_en_i && narrow_wr;
      local_irq_out_n_o <= ~(next_status[`LIS_GLOBAL_EN_BIT] && (|pending));
      host_irq_n_o      <= ~(next_status[`LIS_GLOBAL_EN_BIT] && (|pending)
                             && bridge_gate_i);
    end
  end

endmodule

// >>> include/local_irq_defines.vh
`ifndef LOCAL_IRQ_DEFINES_VH
`define LOCAL_IRQ_DEFINES_VH

// Register offsets on the local register port
`define LIS_STATUS_OFS     8'h10
`define LIS_ENABLE_OFS     8'h14
`define LIS_NETCMD_OFS     8'h1D

// Status and enable bit positions
`define LIS_NI1_BIT        0
`define LIS_NI2_BIT        1
`define LIS_NI3_BIT        2
`define LIS_RST_REQ_BIT    3
`define LIS_TXF_FULL_BIT   5
`define LIS_ROGUE_BIT      6
`define LIS_NI4_BIT        7
`define LIS_BAD_DATA_BIT   8
`define LIS_RXF_AFULL_BIT  9
`define LIS_RXF_FULL_BIT   10
`define LIS_SYNC_LOSS_BIT  11
`define LIS_WR_INH_BIT     12
`define LIS_PARITY_BIT     13
`define LIS_GLOBAL_EN_BIT  14
`define LIS_AUTOCLR_BIT    15

// Latched flags cleared by writing zero
`define LIS_LATCH_MASK     16'h3F68
// Enable bits that exist (bit 14 and bit 4 are reserved there)
`define LIS_ENABLE_MASK    16'hBFEF
// Bridge local configuration bit gating the host interrupt
`define LIS_BRIDGE_GATE_BIT 11

`define LIS_STATUS_RST     16'h0000
`define LIS_ENABLE_RST     16'h0000

// Network interrupt command type codes (low three bits)
`define LIS_CMD_RESET      3'h0
`define LIS_CMD_NI1        3'h1
`define LIS_CMD_NI2        3'h2
`define LIS_CMD_NI3        3'h3
`define LIS_CMD_NI4        3'h7

`endif

// >>> bench/local_irq_status_assertions.sv
module local_irq_status_checker (
  input wire logic        clk_i,             // Clock
  input wire logic        rst_b_i,           // Reset
  input wire logic        reg_wr_i,          // Write
  input wire logic        reg_rd_i,          // Read
  input wire logic [7:0]  reg_addr_i,        // Offset
  input wire logic [31:0] reg_rdata_o,       // Data
  input wire logic        bridge_gate_i,     // Gate
  input wire logic        parity_en_i,       // Parity
  input wire logic        mem_acc_i,         // Access
  input wire logic        mem_wr_i,          // Write
  input wire logic [3:0]  mem_be_i,          // Lanes
  input wire logic        mem_wr_block_o,    // Block
  input wire logic        local_irq_out_n_o, // Local
  input wire logic        host_irq_n_o       // Host
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic narrow, st_rd;
  assign narrow = mem_acc_i && mem_wr_i && parity_en_i && mem_be_i != 4'hF;
  assign st_rd = reg_rd_i && !reg_wr_i && reg_addr_i == 8'h10;
  wr_block_a: assert property (narrow |=> mem_wr_block_o)
    else $error("write not blocked");
  block_cause_a: assert property (mem_wr_block_o |-> $past(narrow))
    else $error("stray block");
  gate_off_a: assert property (!bridge_gate_i [*2] |-> host_irq_n_o)
    else $error("host ungated");
  host_follow_a: assert property ((!local_irq_out_n_o && bridge_gate_i) [*2] |-> !host_irq_n_o)
    else $error("host not raised");
  auto_clear_a: assert property ($past(st_rd) && reg_rdata_o[15] |-> local_irq_out_n_o)
    else $error("auto clear failed");
  resv_zero_a: assert property ($past(reg_rd_i) |-> reg_rdata_o[31:16] == 16'h0 && !reg_rdata_o[4])
    else $error("reserved bits set");
  rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved");
  unmap_zero_a: assert property ($past(reg_rd_i && reg_addr_i != 8'h10 && reg_addr_i != 8'h14)
    |-> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
  cover property (narrow);
  cover property ($past(st_rd) && reg_rdata_o[15]);
  cover property (!host_irq_n_o);
endmodule

bind local_irq_status local_irq_status_checker u_chk (.clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_rdata_o, .bridge_gate_i, .parity_en_i, .mem_acc_i, .mem_wr_i, .mem_be_i,
  .mem_wr_block_o, .local_irq_out_n_o, .host_irq_n_o);

// >>> bench/host_master_model.sv
module host_master_model (
  input  wire logic        clk_i,   // Clock
  input  wire logic [31:0] rdata_i, // Read data
  output logic             wr_o,    // Write strobe
  output logic             rd_o,    // Read strobe
  output logic [7:0]       addr_o,  // Offset
  output logic [31:0]      wdata_o  // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = '0;
  end
  // One access per call, so the caller may pause freely when the receiver fills
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge clk_i);
    // Released data is inverted so a stale word cannot pass for a fresh one
    {wr_o, rd_o, wdata_o} <= {2'b00, ~d};
    #1 q = rdata_i;
  endtask
endmodule

// >>> bench/tb_local_irq_status.sv
module tb_local_irq_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_b_i = 0, bridge_gate_i = 1, parity_en_i = 0, mem_wr_i = 1;
  logic rogue_master_i = 1, mem_acc_i = 0, mem_par_err_i = 0, sync_loss_i = 0, rx_full_i = 0;
  logic rx_afull_i = 0, bad_data_i = 0, rogue_removed_i = 0, tx_full_i = 0, rx_cmd_valid_i = 0;
  logic [2:0] rx_cmd_type_i = 0;
  logic [3:0] queue_nonempty_i = 0, mem_be_i = 0;
  logic reg_wr_i, reg_rd_i, mem_wr_block_o, local_irq_out_n_o, host_irq_n_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  int n_mismatch = 0, tests_run = 0;
  // Row: parity enable and strobes, command type with queues and lanes, expected flags
  logic [36:0] rows [13] = '{{10'h080, 11'h00F, 16'h0800}, {10'h040, 11'h00F, 16'h0400},
    {10'h020, 11'h00F, 16'h0200}, {10'h010, 11'h00F, 16'h0100}, {10'h008, 11'h00F, 16'h0040},
    {10'h004, 11'h00F, 16'h0020}, {10'h002, 11'h00F, 16'h0008}, {10'h002, 11'h70F, 16'h0000},
    {10'h301, 11'h00F, 16'h2000}, {10'h301, 11'h001, 16'h1000}, {10'h101, 11'h00F, 16'h0000},
    {10'h001, 11'h003, 16'h0000}, {10'h000, 11'h0FF, 16'h0087}};
  always #5 clk_i = ~clk_i;
  local_irq_status u_dut (.*);
  host_master_model u_host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    u_host.acc(1'b1, a, v, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e, input logic irq);
    logic [31:0] d;
    u_host.acc(1'b0, a, 32'h0, d);
    tests_run++;
    if (d !== {16'h0, e} || local_irq_out_n_o !== irq
        || host_irq_n_o !== (irq | !bridge_gate_i)) begin
      n_mismatch++;
      $display("MISMATCH %0t read %h irq %b", $time, d, local_irq_out_n_o);
    end
  endtask
  task automatic fire(input logic [20:0] s);
    @(posedge clk_i);
    {parity_en_i, mem_par_err_i, sync_loss_i, rx_full_i, rx_afull_i, bad_data_i, rogue_removed_i,
      tx_full_i, rx_cmd_valid_i, mem_acc_i, rx_cmd_type_i, queue_nonempty_i, mem_be_i} <= s;
    @(posedge clk_i);
    {mem_par_err_i, sync_loss_i, rx_full_i, rx_afull_i, bad_data_i, rogue_removed_i, tx_full_i,
      rx_cmd_valid_i, mem_acc_i} <= '0;
    #1;
    tests_run++;
    if (mem_wr_block_o !== (s[20] && s[11] && s[3:0] != 4'hF)) begin
      n_mismatch++;
      $display("MISMATCH %0t write block %b", $time, mem_wr_block_o);
    end
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    #100us;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1;
    wr(8'h14, 32'h3FEF);
    for (int i = 0; i < 13; i++) begin
      wr(8'h10, 32'h4000);
      fire(rows[i][36:16]);
      chk(8'h10, rows[i][15:0] | 16'h4000, rows[i][15:0] == 0);
      wr(8'h10, 32'hFFFF);
      chk(8'h10, rows[i][15:0] | 16'h4000, rows[i][15:0] == 0);
      fire(21'h0);
      wr(8'h10, 32'h4000);
      chk(8'h10, 16'h4000, 1'b1);
    end
    wr(8'h14, 32'hFFFFFFFF);
    chk(8'h14, 16'hBFEF, 1'b1);
    chk(8'h10, 16'hC000, 1'b1);
    chk(8'h10, 16'h8000, 1'b1);
    wr(8'h10, 32'h4000);
    fire(21'h02000);
    chk(8'h10, 16'hC020, 1'b1);
    wr(8'h14, 32'h3FEF);
    @(posedge clk_i);
    bridge_gate_i <= 0;
    wr(8'h10, 32'h4020);
    chk(8'h10, 16'h4020, 1'b0);
    @(posedge clk_i);
    rst_b_i <= 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    chk(8'h10, 16'h0000, 1'b1);
    chk(8'h14, 16'h0000, 1'b1);
    chk(8'h18, 16'h0000, 1'b1);
    summarize();
  end
endmodule
